//--- verilog/sgpq_queue.sv
`timescale 1ns/1ps
// Summary of operation
// - Effective integral gain is percent times maximum divided by 100 on update.
// - Integral gain percent accepts 0..99, resets to 50.
// - Integral gain maximum accepts 0..32767, resets to 9000, scales the percent.
// - Integral accumulator is clamped to the sum limit; limit 0..214748347, reset 65535.
// - New sum limit reaches nonvolatile storage only on a save command.
// - Maximum following error in steps accepts 0..336544320, resets to 5000.
// - Position error command without value keeps threshold and replies its value.
// - Proportional gain percent accepts 0..99, resets to 15.
// - Updates apply in stream order, after earlier motion commands finish.
// - Integral gain command with a value in 0..99 replaces the stored percent.
module sgpq_queue (
  input wire logic I_CLK_SYS, // System clock, 10 MHz
  input wire logic I_RST_B, // Synchronous reset, active low
  input wire logic I_CMD_VALID, // Command offered
  output logic O_CMD_READY, // Command can be taken
  input wire logic [2:0] I_CMD_KIND, // Command kind
  input wire logic I_CMD_HAS_VALUE, // Value supplied with command
  input wire logic [31:0] I_CMD_VALUE, // Supplied value
  output logic O_MOTION_GO, // Pulse: start queued motion
  input wire logic I_MOTION_DONE, // Motion finished
  output logic O_REPLY_VALID, // Pulse: query answer
  output logic [2:0] O_REPLY_KIND, // Kind being answered
  output logic [31:0] O_REPLY_VALUE, // Value being answered
  output logic O_CMD_REJECT, // Pulse: value out of range
  input wire logic I_NV_VALID, // Stored limit is valid
  input wire logic [27:0] I_NV_SUM_LIMIT, // Stored limit
  output logic O_NV_WRITE, // Pulse: store limit
  output logic [27:0] O_NV_SUM_LIMIT, // Limit to store
  input wire logic I_ERR_VALID, // Position error sample strobe
  input wire logic signed [31:0] I_POS_ERR, // Position error sample
  output logic signed [31:0] O_INTEGRAL_SUM, // Clamped accumulator
  output logic O_FOLLOW_FAULT, // Last error over threshold
  output logic [6:0] O_INTEGRAL_GAIN_PERCENT, // Integral percent
  output logic [14:0] O_INTEGRAL_GAIN_MAXIMUM, // Integral maximum
  output logic [27:0] O_INTEGRAL_SUM_LIMIT, // Accumulator limit
  output logic [28:0] O_MAX_FOLLOWING_ERROR, // Following error limit
  output logic [6:0] O_PROPORTIONAL_GAIN_PERCENT, // Proportional percent
  output logic [14:0] O_INTEGRAL_GAIN // Effective integral gain
);

  // ===================================================================
  // Command decode
  sgpq_pkg::sgpq_state_e state;
  logic restore;
  logic take;
  logic is_param;
  logic in_range;
  logic wr_ok;
  logic [6:0] pct_src;
  logic [14:0] max_src;
  logic [31:0] held;

  // Ready only while idle, so nothing passes a running motion
  assign O_CMD_READY = (state == sgpq_pkg::SGPQ_IDLE) && !restore;
  assign take = I_CMD_VALID && O_CMD_READY;
  assign is_param = (I_CMD_KIND <= sgpq_pkg::KIND_PGAIN);
  assign wr_ok = take && is_param && I_CMD_HAS_VALUE && in_range;

  // Range check and current value per kind
  always_comb begin
    in_range = 1'b0;
    held = 32'h0;
    unique case (I_CMD_KIND)
      sgpq_pkg::KIND_IGAIN: begin
        in_range = I_CMD_VALUE <= sgpq_pkg::PCT_MAX;
        held = {25'h0, O_INTEGRAL_GAIN_PERCENT};
      end
      sgpq_pkg::KIND_IMAX: begin
        in_range = I_CMD_VALUE <= sgpq_pkg::IMAX_MAX;
        held = {17'h0, O_INTEGRAL_GAIN_MAXIMUM};
      end
      sgpq_pkg::KIND_ISUM: begin
        in_range = I_CMD_VALUE <= sgpq_pkg::ISUM_MAX;
        held = {4'h0, O_INTEGRAL_SUM_LIMIT};
      end
      sgpq_pkg::KIND_PERR: begin
        in_range = I_CMD_VALUE <= sgpq_pkg::PERR_MAX;
        held = {3'h0, O_MAX_FOLLOWING_ERROR};
      end
      sgpq_pkg::KIND_PGAIN: begin
        in_range = I_CMD_VALUE <= sgpq_pkg::PCT_MAX;
        held = {25'h0, O_PROPORTIONAL_GAIN_PERCENT};
      end
      default: begin
        in_range = 1'b0;
        held = 32'h0;
      end
    endcase
  end

  // ===================================================================
  // Sequencer: a motion holds back every later command
  // ordered motion hold
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      state <= sgpq_pkg::SGPQ_IDLE;
      O_MOTION_GO <= 1'b0;
    end else begin
      O_MOTION_GO <= take && (I_CMD_KIND == sgpq_pkg::KIND_MOTION);
      unique case (state)
        sgpq_pkg::SGPQ_IDLE: begin
          if (take && (I_CMD_KIND == sgpq_pkg::KIND_MOTION)) begin
            state <= sgpq_pkg::SGPQ_MOTION;
          end
        end
        sgpq_pkg::SGPQ_MOTION: begin
          if (I_MOTION_DONE && !O_MOTION_GO) begin
            state <= sgpq_pkg::SGPQ_IDLE;
          end
        end
      endcase
    end
  end

  // Restore cycle right after reset release
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      restore <= 1'b1;
    end else begin
      restore <= 1'b0;
    end
  end

  // ===================================================================
  // Parameter store
  // guarded percent writes
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      O_INTEGRAL_GAIN_PERCENT <= sgpq_pkg::IGAIN_RST;
      O_PROPORTIONAL_GAIN_PERCENT <= sgpq_pkg::PGAIN_RST;
    end else if (wr_ok) begin
      if (I_CMD_KIND == sgpq_pkg::KIND_IGAIN) begin
        O_INTEGRAL_GAIN_PERCENT <= I_CMD_VALUE[6:0];
      end
      if (I_CMD_KIND == sgpq_pkg::KIND_PGAIN) begin
        O_PROPORTIONAL_GAIN_PERCENT <= I_CMD_VALUE[6:0];
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      O_INTEGRAL_GAIN_MAXIMUM <= sgpq_pkg::IMAX_RST;
      O_MAX_FOLLOWING_ERROR <= sgpq_pkg::PERR_RST;
    end else if (wr_ok) begin
      if (I_CMD_KIND == sgpq_pkg::KIND_IMAX) begin
        O_INTEGRAL_GAIN_MAXIMUM <= I_CMD_VALUE[14:0];
      end
      if (I_CMD_KIND == sgpq_pkg::KIND_PERR) begin
        O_MAX_FOLLOWING_ERROR <= I_CMD_VALUE[28:0];
      end
    end
  end

  // Working limit; stored copy reloads once after reset
  // working copy only
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      O_INTEGRAL_SUM_LIMIT <= sgpq_pkg::ISUM_RST;
    end else if (restore) begin
      if (I_NV_VALID && ({4'h0, I_NV_SUM_LIMIT} <= sgpq_pkg::ISUM_MAX)) begin
        O_INTEGRAL_SUM_LIMIT <= I_NV_SUM_LIMIT;
      end
    end else if (wr_ok && (I_CMD_KIND == sgpq_pkg::KIND_ISUM)) begin
      O_INTEGRAL_SUM_LIMIT <= I_CMD_VALUE[27:0];
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      O_NV_WRITE <= 1'b0;
    end else begin
      O_NV_WRITE <= take && (I_CMD_KIND == sgpq_pkg::KIND_SAVE);
    end
  end
  assign O_NV_SUM_LIMIT = O_INTEGRAL_SUM_LIMIT;

  // ===================================================================
  // Replies and rejects
  // query answer and range reject
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      O_REPLY_VALID <= 1'b0;
      O_REPLY_KIND <= 3'h0;
      O_REPLY_VALUE <= 32'h0;
      O_CMD_REJECT <= 1'b0;
    end else begin
      O_REPLY_VALID <= take && is_param && !I_CMD_HAS_VALUE;
      O_CMD_REJECT <= take && is_param && I_CMD_HAS_VALUE && !in_range;
      if (take && is_param && !I_CMD_HAS_VALUE) begin
        O_REPLY_KIND <= I_CMD_KIND;
        O_REPLY_VALUE <= held;
      end
    end
  end

  // ===================================================================
  // Effective integral gain, fed with the value about to be stored
  // recompute on accepted update
  assign pct_src = (I_CMD_KIND == sgpq_pkg::KIND_IGAIN) ? I_CMD_VALUE[6:0]
                                                         : O_INTEGRAL_GAIN_PERCENT;
  assign max_src = (I_CMD_KIND == sgpq_pkg::KIND_IMAX) ? I_CMD_VALUE[14:0]
                                                        : O_INTEGRAL_GAIN_MAXIMUM;

  sgpq_gain_calc #(
    .PW(sgpq_pkg::PCT_W),
    .MW(sgpq_pkg::IMAX_W)
  ) u_gain (
    .i_clk(I_CLK_SYS),
    .i_rst_b(I_RST_B),
    .i_load(wr_ok && (I_CMD_KIND <= sgpq_pkg::KIND_IMAX)),
    .i_percent(pct_src),
    .i_maximum(max_src),
    .o_gain(O_INTEGRAL_GAIN)
  );

  // ===================================================================
  // Integral accumulator and following error check
  logic signed [33:0] acc_sum;
  logic signed [33:0] lim;
  logic [31:0] err_abs;

  // Wide sum so a large error cannot wrap before clamping
  always_comb begin
    acc_sum = 34'(O_INTEGRAL_SUM) + 34'(I_POS_ERR);
    lim = $signed({6'h0, O_INTEGRAL_SUM_LIMIT});
    err_abs = I_POS_ERR[31] ? 32'(-I_POS_ERR) : I_POS_ERR;
  end

  // clamp to plus or minus limit
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      O_INTEGRAL_SUM <= 32'sh0;
      O_FOLLOW_FAULT <= 1'b0;
    end else if (I_ERR_VALID) begin
      if (acc_sum > lim) begin
        O_INTEGRAL_SUM <= lim[31:0];
      end else if (acc_sum < -lim) begin
        O_INTEGRAL_SUM <= 32'(-lim);
      end else begin
        O_INTEGRAL_SUM <= acc_sum[31:0];
      end
      O_FOLLOW_FAULT <= err_abs > {3'h0, O_MAX_FOLLOWING_ERROR};
    end
  end

  // ===================================================================
  // Checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);

  chk_gain_product: assert property (
    wr_ok && I_CMD_KIND == sgpq_pkg::KIND_IGAIN |=>
      O_INTEGRAL_GAIN == 15'((22'($past(I_CMD_VALUE[6:0])) * O_INTEGRAL_GAIN_MAXIMUM) / 100))
    else $error("effective integral gain wrong");
  chk_igain_range: assert property (
    O_INTEGRAL_GAIN_PERCENT <= 7'd99) else $error("integral percent out of range");
  chk_imax_write: assert property (
    wr_ok && I_CMD_KIND == sgpq_pkg::KIND_IMAX |=>
      O_INTEGRAL_GAIN_MAXIMUM == $past(I_CMD_VALUE[14:0])) else $error("maximum not stored");
  chk_sum_clamp: assert property (
    I_ERR_VALID |=> (O_INTEGRAL_SUM <= $past(lim)) && (O_INTEGRAL_SUM >= -$past(lim)))
    else $error("integral sum beyond limit");
  chk_save_pulse: assert property (
    take && I_CMD_KIND == sgpq_pkg::KIND_SAVE |=>
      O_NV_WRITE && (O_NV_SUM_LIMIT == $past(O_INTEGRAL_SUM_LIMIT)))
    else $error("save did not pulse store");
  chk_save_only: assert property (
    O_NV_WRITE |-> $past(take && I_CMD_KIND == sgpq_pkg::KIND_SAVE))
    else $error("store written without save");
  chk_perr_range: assert property (
    {3'h0, O_MAX_FOLLOWING_ERROR} <= sgpq_pkg::PERR_MAX) else $error("threshold out of range");
  chk_perr_query: assert property (
    take && I_CMD_KIND == sgpq_pkg::KIND_PERR && !I_CMD_HAS_VALUE |=>
      O_REPLY_VALID && $stable(O_MAX_FOLLOWING_ERROR) &&
      O_REPLY_VALUE == {3'h0, O_MAX_FOLLOWING_ERROR}) else $error("query reply wrong");
  chk_pgain_range: assert property (
    O_PROPORTIONAL_GAIN_PERCENT <= 7'd99) else $error("proportional percent out of range");
  chk_motion_hold: assert property (
    O_MOTION_GO ##1 !I_MOTION_DONE |-> !O_CMD_READY) else $error("command passed motion");
  chk_igain_write: assert property (
    wr_ok && I_CMD_KIND == sgpq_pkg::KIND_IGAIN |=>
      O_INTEGRAL_GAIN_PERCENT == $past(I_CMD_VALUE[6:0])) else $error("percent not stored");
  chk_reject_keeps: assert property (
    take && is_param && I_CMD_HAS_VALUE && !in_range |=> O_CMD_REJECT &&
      $stable(O_INTEGRAL_GAIN_PERCENT) && $stable(O_MAX_FOLLOWING_ERROR) &&
      $stable(O_PROPORTIONAL_GAIN_PERCENT)) else $error("rejected value changed state");

  cov_motion: cover property (O_MOTION_GO ##[1:20] O_CMD_READY);
  cov_reject: cover property (O_CMD_REJECT);
  cov_clamp: cover property (I_ERR_VALID && acc_sum > lim);
  cov_save: cover property (O_NV_WRITE);

endmodule // sgpq_queue

//--- shared/sgpq_pkg.sv
// =====================================================================
// Shared constants for the servo gain parameter queue
package sgpq_pkg;

  // ===================================================================
  // Widths
  localparam int PCT_W = 7;
  localparam int IMAX_W = 15;
  localparam int ISUM_W = 28;
  localparam int PERR_W = 29;
  localparam int VAL_W = 32;
  localparam int KIND_W = 3;

  // ===================================================================
  // Command kinds carried in the ordered command stream
  localparam logic [2:0] KIND_IGAIN = 3'h0;
  localparam logic [2:0] KIND_IMAX = 3'h1;
  localparam logic [2:0] KIND_ISUM = 3'h2;
  localparam logic [2:0] KIND_PERR = 3'h3;
  localparam logic [2:0] KIND_PGAIN = 3'h4;
  localparam logic [2:0] KIND_MOTION = 3'h5;
  localparam logic [2:0] KIND_SAVE = 3'h6;

  // ===================================================================
  // Highest accepted values
  localparam logic [31:0] PCT_MAX = 32'h0000_0063;
  localparam logic [31:0] IMAX_MAX = 32'h0000_7fff;
  localparam logic [31:0] ISUM_MAX = 32'h0ccc_ccbb;
  localparam logic [31:0] PERR_MAX = 32'h140f_4240;

  // ===================================================================
  // Values after reset
  localparam logic [6:0] IGAIN_RST = 7'h32;
  localparam logic [14:0] IMAX_RST = 15'h2328;
  localparam logic [27:0] ISUM_RST = 28'h000_ffff;
  localparam logic [28:0] PERR_RST = 29'h0000_1388;
  localparam logic [6:0] PGAIN_RST = 7'h0f;
  localparam logic [14:0] IGAIN_EFF_RST = 15'h1194;

  // ===================================================================
  // Scale divisor of the percentage
  localparam logic [21:0] PCT_SCALE = 22'h00_0064;

  // Sequencer states
  typedef enum logic [0:0] {SGPQ_IDLE, SGPQ_MOTION} sgpq_state_e;

endpackage

//--- verilog/sgpq_gain_calc.sv
`timescale 1ns/1ps
// =====================================================================
// Effective gain: percent times maximum, divided by the scale
module sgpq_gain_calc #(
  parameter int PW = 7,
  parameter int MW = 15
) (
  input wire logic i_clk, // System clock
  input wire logic i_rst_b, // Synchronous reset, active low
  input wire logic i_load, // Recompute strobe
  input wire logic [PW-1:0] i_percent, // Percentage 0..99
  input wire logic [MW-1:0] i_maximum, // Scale maximum
  output logic [MW-1:0] o_gain // Registered effective gain
);

  logic [PW+MW-1:0] product;
  logic [PW+MW-1:0] quotient;

  // Constant divisor keeps this a fixed multiplier network
  always_comb begin
    product = i_percent * i_maximum;
    quotient = product / sgpq_pkg::PCT_SCALE;
  end

  // Result held until the next load
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_gain <= sgpq_pkg::IGAIN_EFF_RST;
    end else if (i_load) begin
      o_gain <= quotient[MW-1:0];
    end
  end

endmodule // sgpq_gain_calc

//--- tb/sgpq_host_model.sv
`timescale 1ns/1ps
// =====================================================================
// Far side: motion executor and nonvolatile store of the sum limit
module sgpq_host_model #(
  parameter int DELAY = 5
) (
  input wire logic i_clk, // System clock
  input wire logic i_motion_go, // Queued motion start
  output logic o_motion_done, // Motion finished pulse
  input wire logic i_nv_write, // Store strobe
  input wire logic [27:0] i_nv_data, // Limit to store
  output logic o_nv_valid, // Store holds a limit
  output logic [27:0] o_nv_data // Stored limit
);
  int cnt;

  // Store starts empty; unwritten data is out of range on purpose
  initial begin
    o_motion_done = 1'b0;
    o_nv_valid = 1'b0;
    o_nv_data = 28'hfff_ffff;
    cnt = 0;
  end

  always @(posedge i_clk) begin
    o_motion_done <= 1'b0;
    if (i_motion_go) begin
      cnt <= DELAY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      o_motion_done <= (cnt == 1);
    end
  end

  always @(posedge i_clk) begin
    if (i_nv_write) begin
      o_nv_valid <= 1'b1;
      o_nv_data <= i_nv_data;
    end
  end
endmodule // sgpq_host_model

//--- tb/sgpq_queue_bench.sv
`timescale 1ns/1ps
// =====================================================================
// Self-checking bench for the parameter queue
module sgpq_queue_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cv = 1'b0;
  logic [2:0] ck = 3'h0;
  logic ch = 1'b0;
  logic [31:0] cval = 32'h0;
  logic ev = 1'b0;
  logic signed [31:0] pe = 32'sh0;
  logic rdy, go, done, rv, rej, nvv, nvw, flt;
  logic [2:0] rk;
  logic [31:0] rval;
  logic [27:0] nvi, nvo, lim;
  logic signed [31:0] isum;
  logic [6:0] ipct, ppct;
  logic [14:0] imax, igain;
  logic [28:0] perr;
  int fails = 0;
  int total_checks = 0;
  int waited = 0;

  sgpq_queue dut (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_CMD_VALID(cv), .O_CMD_READY(rdy),
    .I_CMD_KIND(ck), .I_CMD_HAS_VALUE(ch), .I_CMD_VALUE(cval), .O_MOTION_GO(go),
    .I_MOTION_DONE(done), .O_REPLY_VALID(rv), .O_REPLY_KIND(rk), .O_REPLY_VALUE(rval),
    .O_CMD_REJECT(rej), .I_NV_VALID(nvv), .I_NV_SUM_LIMIT(nvi), .O_NV_WRITE(nvw),
    .O_NV_SUM_LIMIT(nvo), .I_ERR_VALID(ev), .I_POS_ERR(pe), .O_INTEGRAL_SUM(isum),
    .O_FOLLOW_FAULT(flt), .O_INTEGRAL_GAIN_PERCENT(ipct), .O_INTEGRAL_GAIN_MAXIMUM(imax),
    .O_INTEGRAL_SUM_LIMIT(lim), .O_MAX_FOLLOWING_ERROR(perr),
    .O_PROPORTIONAL_GAIN_PERCENT(ppct), .O_INTEGRAL_GAIN(igain));

  sgpq_host_model #(.DELAY(5)) host (.i_clk(clk), .i_motion_go(go), .o_motion_done(done),
    .i_nv_write(nvw), .i_nv_data(nvo), .o_nv_valid(nvv), .o_nv_data(nvi));

  // Free-running 100 ns clock
  initial begin
    forever #50 clk = ~clk;
  end

  // =====================================================================
  // Shared tasks
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Offer at a falling edge, hold until a rising edge sees ready
  // Leading wait keeps a cycle with valid low between two commands
  task automatic send(input logic [2:0] k, input logic h, input logic [31:0] v);
    @(negedge clk);
    cv = 1'b1;
    ck = k;
    ch = h;
    cval = v;
    waited = 0;
    while (rdy !== 1'b1) begin
      @(negedge clk);
      waited++;
      if (waited > 200) begin
        fails++;
        complete_run();
      end
    end
    @(negedge clk);
    cv = 1'b0;
  endtask

  task automatic sample(input logic signed [31:0] e);
    @(negedge clk);
    ev = 1'b1;
    pe = e;
    @(negedge clk);
    ev = 1'b0;
  endtask

  task automatic do_reset();
    rst_b = 1'b0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
  endtask

  // =====================================================================
  // Scenarios
  task automatic t_defaults();
    check(ipct, 32'h32);
    check(imax, 32'h2328);
    check(lim, 32'hffff);
    check(perr, 32'h1388);
    check(ppct, 32'hf);
    check(igain, 32'h1194);
  endtask

  task automatic t_gains();
    send(sgpq_pkg::KIND_IGAIN, 1'b1, 32'h14);
    check(ipct, 32'h14);
    check(igain, 32'h708);
    send(sgpq_pkg::KIND_IGAIN, 1'b1, 32'h63);
    check(igain, 32'h22ce);
    send(sgpq_pkg::KIND_IGAIN, 1'b1, 32'h64);
    check(rej, 32'h1);
    check(ipct, 32'h63);
    send(sgpq_pkg::KIND_IGAIN, 1'b0, 32'h0);
    check({rv, rk}, 32'h8);
    check(rval, 32'h63);
    send(sgpq_pkg::KIND_IMAX, 1'b1, 32'h7fff);
    check(igain, 32'h7eb7);
    send(sgpq_pkg::KIND_IMAX, 1'b1, 32'h8000);
    check(rej, 32'h1);
    check(imax, 32'h7fff);
    send(sgpq_pkg::KIND_PGAIN, 1'b1, 32'h63);
    check(ppct, 32'h63);
    send(sgpq_pkg::KIND_PGAIN, 1'b1, 32'h64);
    check(rej, 32'h1);
    check(ppct, 32'h63);
  endtask

  task automatic t_position_error();
    send(sgpq_pkg::KIND_PERR, 1'b0, 32'h0);
    check({rv, rk}, 32'hb);
    check(rval, 32'h1388);
    check(perr, 32'h1388);
    send(sgpq_pkg::KIND_PERR, 1'b1, 32'h140f_4240);
    check(perr, 32'h140f_4240);
    send(sgpq_pkg::KIND_PERR, 1'b1, 32'h140f_4241);
    check(rej, 32'h1);
    check(perr, 32'h140f_4240);
  endtask

  task automatic t_clamp();
    send(sgpq_pkg::KIND_ISUM, 1'b1, 32'h0ccc_ccbb);
    send(sgpq_pkg::KIND_ISUM, 1'b1, 32'h0ccc_ccbc);
    check(lim, 32'h0ccc_ccbb);
    send(sgpq_pkg::KIND_ISUM, 1'b1, 32'h64);
    send(sgpq_pkg::KIND_PERR, 1'b1, 32'h32);
    sample(32'sh3c);
    check(isum, 32'h3c);
    check(flt, 32'h1);
    sample(32'sh3c);
    check(isum, 32'h64);
    sample(-32'sd300);
    check(isum, 32'hffff_ff9c);
    sample(32'sha);
    check(flt, 32'h0);
    check(isum, 32'hffff_ffa6);
  endtask

  // Unsaved limit must not survive a reset
  task automatic t_save();
    send(sgpq_pkg::KIND_SAVE, 1'b1, 32'h0);
    check({nvw, nvo}, 32'h1000_0064);
    send(sgpq_pkg::KIND_ISUM, 1'b1, 32'hc8);
    check(nvw, 32'h0);
    check(lim, 32'hc8);
    do_reset();
    @(negedge clk);
    check(lim, 32'h64);
    check(ipct, 32'h32);
  endtask

  task automatic t_queue();
    send(sgpq_pkg::KIND_MOTION, 1'b1, 32'h0);
    check({go, rdy}, 32'h2);
    send(sgpq_pkg::KIND_PGAIN, 1'b1, 32'h28);
    check(waited >= 3, 32'h1);
    check(ppct, 32'h28);
    send(3'h7, 1'b1, 32'h0);
    check({rv, rej, ppct}, 32'h28);
  endtask

  // =====================================================================
  // Main sequence
  initial begin
    do_reset();
    @(negedge clk);
    t_defaults();
    t_gains();
    t_position_error();
    t_clamp();
    t_save();
    t_queue();
    complete_run();
  end
endmodule // sgpq_queue_bench
